/* hdl/dtj_pkg.sv */
`default_nettype none
package dtj_pkg;
  localparam int IR_WIDTH = 4;
  localparam logic [3:0] INSN_EXTEST    = 4'h0;
  localparam logic [3:0] INSN_SAMPLE    = 4'h1;
  localparam logic [3:0] INSN_CHIP_IDENTITY_WORD    = 4'h2;
  localparam logic [3:0] INSN_USERCODE  = 4'h3;
  localparam logic [3:0] INSN_DBG_ACCESS = 4'h8;
  localparam logic [3:0] INSN_OTP_ACCESS = 4'h9;
  localparam logic [3:0] INSN_BYPASS    = 4'hF;
  localparam logic [3:0] IR_CAPTURE     = 4'h1;
  // identity fields: values arbitrary, not tied to any maker
  localparam logic [3:0]  ID_VERSION  = 4'h0;
  localparam logic [15:0] ID_PART     = 16'h0001;
  localparam logic [10:0] ID_MAKER    = 11'h001;
  localparam logic [15:0] SILICON_REV = 16'h0001;
  localparam int USER_ID_LSB = 22;
  localparam int USER_ID_MSB = 31;
  localparam int USER_ID_W   = 10;
  localparam int UNUSED_W    = 6;
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_OTP_OFF  = 13;
  localparam int BSR_WIDTH   = 8;
  localparam int DBG_WIDTH   = 32;
  typedef enum logic [3:0] {
    TestLogicReset = 4'b0000, RunIdle   = 4'b0001, SelectDr  = 4'b0010,
    CaptureDr      = 4'b0011, ShiftDr   = 4'b0100, Exit1Dr   = 4'b0101,
    PauseDr        = 4'b0110, Exit2Dr   = 4'b0111, UpdateDr  = 4'b1000,
    SelectIr       = 4'b1001, CaptureIr = 4'b1010, ShiftIr   = 4'b1011,
    Exit1Ir        = 4'b1100, PauseIr   = 4'b1101, Exit2Ir   = 4'b1110,
    UpdateIr       = 4'b1111
  } dtj_tap_state_type;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dtj_jtag_in_type;
endpackage : dtj_pkg
`default_nettype wire

/* hdl/dtj_tap_chain.sv */
// Contract
// - port serves program load, boundary scan, debug and OTP programming.
// - after reset chain holds two TAPs: boundary scan then chip TAP.
// - boundary-scan TAP follows 1149.1 and scans the I/O pins.
// - chip TAP reaches tile, switch and OTP for load and debug.
// - test reset low keeps all test logic in reset; here it passes two clk flops and leaves pinOut, bsrHold and dbgWord alone.
// - CHIP_IDENTITY_WORD gives 32-bit ID: version, part, maker, bit 0 one.
// - USERCODE gives user id high, unused span, silicon revision low.
// - user id comes from security register bits 22 to 31.
// - unprogrammed OTP gives user id all zeros.
// - global reset active low, asynchronous, resets everything; here it passes two clk flops and leaves pinOut, bsrHold and dbgWord alone.
// - after global reset wait for PLL lock before booting.
// - security bit 0 disables the test interface entirely.
// - security bit 13 refuses test reads and writes of OTP.
`default_nettype none
module dtj_tap_chain
  import dtj_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 globalRst_n,
  input  wire logic                 testRst_n,
  input  wire dtj_jtag_in_type      jtagIn,
  input  wire logic                 pllLocked,
  input  wire logic [31:0]          securityWord,
  input  wire logic                 otpProgrammed,
  input  wire logic [BSR_WIDTH-1:0] pinIn,
  output logic                      tdo,
  output logic                      tdoOe_n,
  output logic [BSR_WIDTH-1:0]      pinOut,
  output logic                      pinTestMode,
  output logic [DBG_WIDTH-1:0]      dbgWord,
  output logic                      dbgStrobe,
  output logic                      otpAccess,
  output logic                      otpRefused,
  output logic                      bootGo
);
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic       tckLast;
  logic       rstSyncA;
  logic       rstSyncB;
  logic       tckRise;
  logic       tckFall;
  logic       resetAll;
  logic       jtagOff;
  logic       tms;
  logic       tdi;
  logic       glbSyncA;
  logic       glbSyncB;
  logic [BSR_WIDTH-1:0] pinSyncA;
  logic [BSR_WIDTH-1:0] pinSyncB;

  // pins pass two flops; only the second stage is read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA   <= 3'h0;
      syncB   <= 3'h0;
      tckLast <= 1'b0;
      rstSyncA <= 1'b0;
      rstSyncB <= 1'b0;
      glbSyncA <= 1'b0;
      glbSyncB <= 1'b0;
      pinSyncA <= '0;
      pinSyncB <= '0;
    end else begin
      syncA   <= {jtagIn.tck, jtagIn.tms, jtagIn.tdi};
      syncB   <= syncA;
      tckLast <= syncB[2];
      rstSyncA <= testRst_n & globalRst_n;
      rstSyncB <= rstSyncA;
      glbSyncA <= globalRst_n;
      glbSyncB <= glbSyncA;
      pinSyncA <= pinIn;
      pinSyncB <= pinSyncA;
    end
  end

  assign tms      = syncB[1];
  assign tdi      = syncB[0];
  assign tckRise  = syncB[2] & ~tckLast;
  assign tckFall  = ~syncB[2] & tckLast;
  assign resetAll = ~rstSyncB;
  assign jtagOff  = securityWord[SEC_JTAG_OFF];

  // two TAPs in series: bscan first (tdi side), chip TAP last (tdo side)
  dtj_tap_state_type state [2];
  logic [IR_WIDTH-1:0] irShift [2];
  logic [IR_WIDTH-1:0] ir [2];
  logic [31:0] drShift [2];
  logic [BSR_WIDTH-1:0] bsrHold;
  logic [1:0] serialOut;
  logic [1:0] serialIn;

  assign serialIn[0] = tdi;
  assign serialIn[1] = serialOut[0];

  function automatic dtj_tap_state_type nextState(input dtj_tap_state_type s,
                                                  input logic m);
    unique case (s)
      TestLogicReset: nextState = m ? TestLogicReset : RunIdle;
      RunIdle:        nextState = m ? SelectDr : RunIdle;
      SelectDr:       nextState = m ? SelectIr : CaptureDr;
      CaptureDr:      nextState = m ? Exit1Dr : ShiftDr;
      ShiftDr:        nextState = m ? Exit1Dr : ShiftDr;
      Exit1Dr:        nextState = m ? UpdateDr : PauseDr;
      PauseDr:        nextState = m ? Exit2Dr : PauseDr;
      Exit2Dr:        nextState = m ? UpdateDr : ShiftDr;
      UpdateDr:       nextState = m ? SelectDr : RunIdle;
      SelectIr:       nextState = m ? TestLogicReset : CaptureIr;
      CaptureIr:      nextState = m ? Exit1Ir : ShiftIr;
      ShiftIr:        nextState = m ? Exit1Ir : ShiftIr;
      Exit1Ir:        nextState = m ? UpdateIr : PauseIr;
      PauseIr:        nextState = m ? Exit2Ir : PauseIr;
      Exit2Ir:        nextState = m ? UpdateIr : ShiftIr;
      UpdateIr:       nextState = m ? SelectDr : RunIdle;
    endcase
  endfunction : nextState

  // capture value per selected register
  function automatic logic [31:0] captureWord(input logic [IR_WIDTH-1:0] insn,
                                              input logic chipTap,
                                              input logic [31:0] sec,
                                              input logic prog,
                                              input logic [BSR_WIDTH-1:0] pins);
    logic [USER_ID_W-1:0] userId;
    userId = prog ? sec[USER_ID_MSB:USER_ID_LSB] : {USER_ID_W{1'b0}};
    captureWord = 32'h0000_0000;
    if (insn == INSN_CHIP_IDENTITY_WORD) begin
      captureWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    end else if (insn == INSN_USERCODE) begin
      captureWord = {userId, {UNUSED_W{1'b0}}, SILICON_REV};
    end else if (!chipTap && (insn == INSN_SAMPLE || insn == INSN_EXTEST)) begin
      captureWord = {{(32-BSR_WIDTH){1'b0}}, pins};
    end
  endfunction : captureWord

  // shift length: bypass 1, bscan SAMPLE/EXTEST BSR_WIDTH, rest 32
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      if (ir[t] == INSN_BYPASS) begin
        serialOut[t] = drShift[t][0];
      end else if (t == 0 && (ir[t] == INSN_SAMPLE || ir[t] == INSN_EXTEST)) begin
        serialOut[t] = drShift[t][0];
      end else begin
        serialOut[t] = drShift[t][0];
      end
      if (state[t] == ShiftIr) begin
        serialOut[t] = irShift[t][0];
      end
    end
  end

  for (genvar t = 0; t < 2; t++) begin : gTap
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        state[t]   <= TestLogicReset;
        irShift[t] <= IR_CAPTURE;
        ir[t]      <= INSN_CHIP_IDENTITY_WORD;
        drShift[t] <= 32'h0000_0000;
      end else if (resetAll || jtagOff) begin
        state[t]   <= TestLogicReset;
        ir[t]      <= INSN_CHIP_IDENTITY_WORD;
      end else if (tckRise) begin
        state[t] <= nextState(state[t], tms);
        unique case (state[t])
          TestLogicReset: ir[t] <= INSN_CHIP_IDENTITY_WORD;
          CaptureIr:      irShift[t] <= IR_CAPTURE;
          ShiftIr:        irShift[t] <= {serialIn[t], irShift[t][IR_WIDTH-1:1]};
          UpdateIr:       ir[t] <= irShift[t];
          CaptureDr:      drShift[t] <= captureWord(ir[t], t == 1, securityWord,
                                                    otpProgrammed, pinSyncB);
          ShiftDr: begin
            if (ir[t] == INSN_BYPASS) begin
              drShift[t] <= {31'h0000_0000, serialIn[t]};
            end else if (t == 0 && (ir[t] == INSN_SAMPLE || ir[t] == INSN_EXTEST)) begin
              drShift[t] <= {{(32-BSR_WIDTH){1'b0}}, serialIn[t],
                             drShift[t][BSR_WIDTH-1:1]};
            end else begin
              drShift[t] <= {serialIn[t], drShift[t][31:1]};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // boundary-scan update and pin takeover
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bsrHold     <= '0;
      pinOut      <= '0;
      pinTestMode <= 1'b0;
    end else if (resetAll || jtagOff) begin
      pinTestMode <= 1'b0;
    end else if (tckRise) begin
      if (state[0] == UpdateDr && ir[0] == INSN_EXTEST) begin
        bsrHold <= drShift[0][BSR_WIDTH-1:0];
        pinOut  <= drShift[0][BSR_WIDTH-1:0];
      end
      pinTestMode <= (ir[0] == INSN_EXTEST) && (state[0] != TestLogicReset);
    end
  end

  // chip TAP debug and OTP path; OTP blocked by security bit 13
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dbgWord    <= '0;
      dbgStrobe  <= 1'b0;
      otpAccess  <= 1'b0;
      otpRefused <= 1'b0;
    end else begin
      dbgStrobe  <= 1'b0;
      otpAccess  <= 1'b0;
      otpRefused <= 1'b0;
      if (!resetAll && !jtagOff && tckRise && state[1] == UpdateDr) begin
        if (ir[1] == INSN_DBG_ACCESS) begin
          dbgWord   <= drShift[1];
          dbgStrobe <= 1'b1;
        end else if (ir[1] == INSN_OTP_ACCESS) begin
          if (securityWord[SEC_OTP_OFF]) begin
            otpRefused <= 1'b1;
          end else begin
            dbgWord   <= drShift[1];
            otpAccess <= 1'b1;
          end
        end
      end
    end
  end

  // tdo changes on falling tck, driven only in shift states
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tdo     <= 1'b0;
      tdoOe_n <= 1'b1;
    end else if (resetAll || jtagOff) begin
      tdo     <= 1'b0;
      tdoOe_n <= 1'b1;
    end else if (tckFall) begin
      tdo     <= serialOut[1];
      tdoOe_n <= !(state[1] == ShiftDr || state[1] == ShiftIr);
    end
  end

  // boot waits for PLL lock after global reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bootGo <= 1'b0;
    end else if (!glbSyncB) begin
      bootGo <= 1'b0;
    end else if (pllLocked) begin
      bootGo <= 1'b1;
    end
  end
endmodule : dtj_tap_chain
`default_nettype wire

/* tb/dtj_tap_chain_assertions.sv */
`default_nettype none
module dtj_tap_chain_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        globalRst_n,
  input wire logic        testRst_n,
  input wire logic        pllLocked,
  input wire logic [31:0] securityWord,
  input wire logic        tdoOe_n,
  input wire logic        dbgStrobe,
  input wire logic        otpAccess,
  input wire logic        otpRefused,
  input wire logic        bootGo
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // six clk covers the two-flop sync plus the tap reset itself
  property p_testRstOff;
    !testRst_n [*6] |-> tdoOe_n && !dbgStrobe && !otpAccess;
  endproperty
  a_testRstOff: assert property (p_testRstOff) else $error("test logic active in reset");
  property p_secOff;
    securityWord[0] [*6] |-> tdoOe_n && !dbgStrobe && !otpAccess;
  endproperty
  a_secOff: assert property (p_secOff) else $error("port live while disabled");
  property p_glbOff;
    !globalRst_n [*4] |-> !bootGo;
  endproperty
  a_glbOff: assert property (p_glbOff) else $error("boot during global reset");
  property p_bootNeedsPll;
    $rose(bootGo) |-> $past(pllLocked);
  endproperty
  a_bootNeedsPll: assert property (p_bootNeedsPll) else $error("boot without lock");
  property p_bootGo;
    (globalRst_n && pllLocked) [*6] |-> bootGo;
  endproperty
  a_bootGo: assert property (p_bootGo) else $error("boot late");
  property p_otpExcl;
    otpRefused |-> !otpAccess && $past(securityWord[13]);
  endproperty
  a_otpExcl: assert property (p_otpExcl) else $error("refused and granted");
  property p_otpLocked;
    otpAccess |-> !securityWord[13] && !$past(securityWord[13]);
  endproperty
  a_otpLocked: assert property (p_otpLocked) else $error("locked otp reached");
  property p_refusePulse;
    otpRefused |=> !otpRefused;
  endproperty
  a_refusePulse: assert property (p_refusePulse) else $error("refusal not a pulse");
endmodule : dtj_tap_chain_checker
bind dtj_tap_chain dtj_tap_chain_checker u_chk (.clk, .sys_rst, .globalRst_n, .testRst_n,
  .pllLocked, .securityWord, .tdoOe_n, .dbgStrobe, .otpAccess, .otpRefused, .bootGo);
`default_nettype wire

/* tb/dtj_jtag_host.sv */
`default_nettype none
module dtj_jtag_host
  import dtj_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          tdo,
  input  wire logic          tdoOe_n,
  output var dtj_jtag_in_type jtagIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial jtagIn = '0;
  // tck idles low between frames; tdo read late in the high phase, after it settles
  // a released data line reads inverted, so a silent port cannot pass as data
  task automatic step(input logic tms, input logic tdi, output logic tdoBit);
    jtagIn.tms <= tms;
    jtagIn.tdi <= tdi;
    repeat (4) @(posedge clk);
    jtagIn.tck <= 1'b1;
    repeat (4) @(posedge clk);
    tdoBit = tdoOe_n ? ~tdo : tdo;
    jtagIn.tck <= 1'b0;
  endtask : step
endmodule : dtj_jtag_host
`default_nettype wire

/* tb/dual_tap_jtag_chain_tb.sv */
`default_nettype none
module dual_tap_jtag_chain_tb
  import dtj_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] IdWord = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [31:0] SecVal = 32'hA5C0_0000;
  localparam logic [31:0] DbgVal = 32'h5AC3_96E1;
  localparam logic [31:0] OtpVal = 32'h0F1E_2D3C;
  logic            clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            globalRst_n = 1'b0;
  logic            testRst_n = 1'b0;
  logic            pllLocked = 1'b0;
  logic [31:0]     securityWord = SecVal;
  logic            otpProgrammed = 1'b1;
  logic            tdo, tdoOe_n, dbgStrobe, otpAccess, otpRefused, bootGo;
  logic [BSR_WIDTH-1:0] pinIn = 8'h5A;
  logic [BSR_WIDTH-1:0] pinOut;
  logic                 pinTestMode;
  logic [DBG_WIDTH-1:0] dbgWord;
  int                   dbgCount = 0;
  dtj_jtag_in_type jtagIn;
  int              numErrors = 0;
  int              samplesChecked = 0;
  int              accCount = 0;
  int              refCount = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (otpAccess === 1'b1) accCount++;
    if (otpRefused === 1'b1) refCount++;
    if (dbgStrobe === 1'b1) dbgCount++;
  end
  dtj_tap_chain dut (.clk, .sys_rst, .globalRst_n, .testRst_n, .jtagIn, .pllLocked,
    .securityWord, .otpProgrammed, .pinIn, .tdo, .tdoOe_n, .pinOut,
    .pinTestMode, .dbgWord, .dbgStrobe, .otpAccess, .otpRefused, .bootGo);
  dtj_jtag_host host (.clk, .tdo, .tdoOe_n, .jtagIn);
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    samplesChecked++;
    if (seen !== want) begin
      numErrors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic shift(input logic [63:0] tms, input logic [63:0] tdi, input int n,
                       output logic [63:0] out);
    logic b;
    out = '0;
    for (int i = 0; i < n; i++) begin
      host.step(tms[i], tdi[i], b);
      out[i] = b;
    end
  endtask : shift
  // from idle: preamble to shift, n bits, then update and back to idle
  task automatic scan(input logic isIr, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    logic [63:0] junk;
    shift(isIr ? 64'h3 : 64'h1, 64'h0, isIr ? 4 : 3, junk);
    shift(64'h1 << (n - 1), din, n, dout);
    shift(64'h1, 64'h0, 2, junk);
  endtask : scan
  task automatic tapIdle();
    logic [63:0] junk;
    shift(64'h1F, 64'h0, 6, junk);
  endtask : tapIdle
  task automatic tBoot();
    repeat (20) @(posedge clk);
    check(bootGo, 1'b0);
    pllLocked <= 1'b1;
    repeat (10) @(posedge clk);
    check(bootGo, 1'b1);
    globalRst_n <= 1'b0;
    repeat (6) @(posedge clk);
    check(bootGo, 1'b0);
    globalRst_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : tBoot
  task automatic tIdcode();
    logic [63:0] d;
    tapIdle();
    scan(1'b0, 64'h0, 64, d);
    check(d, {IdWord, IdWord});
  endtask : tIdcode
  task automatic tUser();
    logic [63:0] d;
    for (int p = 0; p < 2; p++) begin
      otpProgrammed <= p[0];
      tapIdle();
      scan(1'b1, {56'h0, INSN_BYPASS, INSN_USERCODE}, 8, d);
      check(d[7:0], {IR_CAPTURE, IR_CAPTURE});
      scan(1'b0, 64'h0, 33, d);
      check(d[31:0], {p ? SecVal[31:22] : 10'h0, 6'h0, SILICON_REV});
    end
  endtask : tUser
  // both scan modes capture the pins; only EXTEST takes the pins over
  task automatic tScan();
    logic [63:0] d;
    tapIdle();
    scan(1'b1, {56'h0, INSN_SAMPLE, INSN_BYPASS}, 8, d);
    scan(1'b0, {55'h0, 8'hC3, 1'b0}, 9, d);
    check(d[8:1], 8'h5A);
    check(pinTestMode, 1'b0);
    pinIn <= 8'h3C;
    scan(1'b1, {56'h0, INSN_EXTEST, INSN_BYPASS}, 8, d);
    scan(1'b0, {55'h0, 8'h96, 1'b0}, 9, d);
    check(d[8:1], 8'h3C);
    check(pinOut, 8'h96);
    check(pinTestMode, 1'b1);
    tapIdle();
    check(pinTestMode, 1'b0);
  endtask : tScan
  task automatic tDbg();
    logic [63:0] d;
    dbgCount = 0;
    tapIdle();
    scan(1'b1, {56'h0, INSN_BYPASS, INSN_DBG_ACCESS}, 8, d);
    scan(1'b0, {32'h0, DbgVal}, 33, d);
    repeat (8) @(posedge clk);
    check(dbgCount, 1);
    check(dbgWord, DbgVal);
  endtask : tDbg
  task automatic tOtp();
    logic [63:0] d;
    for (int i = 0; i < 2; i++) begin
      securityWord[SEC_OTP_OFF] <= i[0];
      accCount = 0;
      refCount = 0;
      tapIdle();
      scan(1'b1, {56'h0, INSN_BYPASS, INSN_OTP_ACCESS}, 8, d);
      scan(1'b0, {32'h0, i ? ~OtpVal : OtpVal}, 33, d);
      repeat (8) @(posedge clk);
      check(accCount, 1 - i);
      check(dbgWord, OtpVal);
      check(refCount, i);
    end
    securityWord <= SecVal;
  endtask : tOtp
  // a held instruction must fall back to identity on test reset
  task automatic tTestRst();
    logic [63:0] d;
    tapIdle();
    scan(1'b1, {56'h0, INSN_USERCODE, INSN_USERCODE}, 8, d);
    // reset lands mid-shift, with the data line driven
    shift(64'h1, 64'h0, 3, d);
    repeat (4) @(posedge clk);
    check(tdoOe_n, 1'b0);
    testRst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check(tdoOe_n, 1'b1);
    testRst_n <= 1'b1;
    repeat (6) @(posedge clk);
    shift(64'h0, 64'h0, 1, d);
    scan(1'b0, 64'h0, 64, d);
    check(d, {IdWord, IdWord});
  endtask : tTestRst
  task automatic tDisable();
    logic [63:0] d;
    securityWord[SEC_JTAG_OFF] <= 1'b1;
    repeat (8) @(posedge clk);
    tapIdle();
    scan(1'b0, 64'h0, 8, d);
    // port off: line released over a low data register, so it reads all ones
    check(d[7:0], 8'hFF);
    check(tdoOe_n, 1'b1);
    securityWord <= SecVal;
  endtask : tDisable
  task automatic wrapUp();
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrapUp
  initial begin
    repeat (50000) @(posedge clk);
    numErrors++;
    wrapUp();
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    globalRst_n <= 1'b1;
    testRst_n <= 1'b1;
    tBoot();
    tIdcode();
    tUser();
    tScan();
    tDbg();
    tOtp();
    tTestRst();
    tDisable();
    wrapUp();
  end
endmodule : dual_tap_jtag_chain_tb
`default_nettype wire
